// ### ctrl_pin_pkg.sv
// Constants and types shared by the control pin function select block.
`default_nettype none
package ctrl_pin_pkg;
  // Positions of the pins inside the synchroniser vector.
  localparam int SYNC_W = 5;
  localparam int SY_RST = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_SDIN = 2;
  localparam int SY_SEL = 3;
  localparam int SY_OE = 4;
  // Serially programmed configuration bank.
  localparam int CFG_N = 4;
  localparam int CFG_AW = 2;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  localparam logic [CFG_AW-1:0] CFG_CTRL_IDX = 2'h0;
  localparam logic [CFG_AW-1:0] CFG_PWR_IDX = 2'h1;
  localparam int CFG_RB_BIT = 0;
  localparam int CFG_SWRST_BIT = 1;
  localparam int CFG_STBY_BIT = 0;
  // Serial frame: eight address bits then eight data bits, first bit most significant.
  localparam int BCNT_W = 5;
  localparam logic [BCNT_W-1:0] ADDR_BITS = 5'h08;
  localparam logic [BCNT_W-1:0] FRAME_BITS = 5'h10;
  // Wishbone register byte addresses.
  localparam int WB_AW = 4;
  localparam logic [WB_AW-1:0] ADR_STATUS = 4'h0;
  localparam logic [WB_AW-1:0] ADR_MASK = 4'h4;
  localparam logic [WB_AW-1:0] ADR_STATE = 4'h8;
  localparam logic [WB_AW-1:0] ADR_CFG = 4'hc;
  // Event bits, same layout in status and mask.
  localparam int EV_W = 3;
  localparam int EV_WRITE = 0;
  localparam int EV_SWRST = 1;
  localparam int EV_MODE = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  // Fields of the state register.
  localparam int ST_PARALLEL = 0;
  localparam int ST_READBACK = 1;
  localparam int ST_STANDBY = 2;
  localparam int ST_BUFEN = 3;
  localparam int ST_PARCTRL = 4;
  localparam int ST_PHASE_LSB = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} phase_t;
endpackage
`default_nettype wire

// ### ctrl_pin_select.sv
// Control pin function select: serial programming port, parallel pins and shared flag pin.
`default_nettype none
module ctrl_pin_select
  import ctrl_pin_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic irq_o,
  input wire logic reset_pin_i,
  input wire logic sclk_i,
  input wire logic serial_in_line_i,
  input wire logic serial_select_i,
  input wire logic output_drive_en_i,
  input wire logic range_over_i,
  output logic range_flag_or_readback_out_o,
  output logic buffers_en_o,
  output logic drivers_oe_n_o,
  output logic standby_o,
  output logic parallel_ctrl_o
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [SYNC_W-1:0] sy1;
    logic [SYNC_W-1:0] sy2;
    logic sclk_d;
    logic mode_d;
    phase_t phase;
    logic [BCNT_W-1:0] bcnt;
    logic [7:0] addr;
    logic [7:0] shift;
    logic [7:0] rd;
    logic [CFG_N-1:0][7:0] cfg;
    logic [EV_W-1:0] sts;
    logic [EV_W-1:0] msk;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic pin;
    logic buf_en;
    logic drv_oe_n;
    logic stby;
    logic par;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic par_mode;
  logic sclk_rise;
  logic sel_n;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic wb_req;
  logic [7:0] wdata;
  logic [CFG_AW-1:0] widx;

  assign par_mode = st_r.sy2[SY_RST];
  assign sclk_rise = st_r.sy2[SY_SCLK] & ~st_r.sclk_d;
  assign sel_n = st_r.sy2[SY_SEL];
  assign wb_req = wb_cyc_i & wb_stb_i & ~st_r.ack;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    ev = '0;
    clr = '0;
    wdata = {st_r.shift[6:0], st_r.sy2[SY_SDIN]};
    widx = st_r.addr[CFG_AW-1:0];
    // Pins come from outside the clock domain; only the second stage is ever read.
    st_nxt.sy1 = {output_drive_en_i, serial_select_i, serial_in_line_i, sclk_i, reset_pin_i};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.sclk_d = st_r.sy2[SY_SCLK];
    st_nxt.mode_d = par_mode;
    if (st_r.mode_d != par_mode) begin
      ev[EV_MODE] = 1'b1;
    end
    if (par_mode) begin
      // Holding the registers at default also serves as the hardware reset pulse.
      st_nxt.cfg = {CFG_N{CFG_DEFAULT}};
      st_nxt.phase = PH_IDLE;
      st_nxt.bcnt = '0;
      st_nxt.rd = '0;
    end else if (sel_n) begin
      st_nxt.phase = PH_IDLE;
      st_nxt.bcnt = '0;
    end else if (sclk_rise) begin
      st_nxt.shift = wdata;
      st_nxt.bcnt = st_r.bcnt + 5'h01;
      st_nxt.rd = {st_r.rd[6:0], 1'b0};
      st_nxt.phase = PH_ADDR;
      if (st_r.bcnt + 5'h01 == ADDR_BITS) begin
        st_nxt.addr = wdata;
        st_nxt.phase = PH_DATA;
        // Addresses beyond the bank read back as zero.
        if (wdata[7:CFG_AW] == '0) begin
          st_nxt.rd = st_r.cfg[wdata[CFG_AW-1:0]];
        end else begin
          st_nxt.rd = '0;
        end
      end else if (st_r.bcnt + 5'h01 == FRAME_BITS) begin
        st_nxt.phase = PH_IDLE;
        st_nxt.bcnt = '0;
        // In readback mode only the control register stays writable, so it can be left.
        if (st_r.addr[7:CFG_AW] == '0 &&
            (!st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT] || widx == CFG_CTRL_IDX)) begin
          ev[EV_WRITE] = 1'b1;
          if (widx == CFG_CTRL_IDX && wdata[CFG_SWRST_BIT]) begin
            st_nxt.cfg = {CFG_N{CFG_DEFAULT}};
            ev[EV_SWRST] = 1'b1;
          end else begin
            st_nxt.cfg[widx] = wdata;
          end
        end
      end
    end
    // Pin functions.
    st_nxt.buf_en = st_r.sy2[SY_OE];
    st_nxt.drv_oe_n = ~st_r.sy2[SY_OE];
    if (st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT]) begin
      st_nxt.pin = st_r.rd[7];
    end else begin
      st_nxt.pin = range_over_i;
    end
    if (par_mode) begin
      st_nxt.stby = st_r.sy2[SY_SDIN];
      st_nxt.par = sel_n;
    end else begin
      st_nxt.stby = st_r.cfg[CFG_PWR_IDX][CFG_STBY_BIT];
      st_nxt.par = 1'b0;
    end
    // Wishbone slave: one wait state, ack for exactly one cycle.
    st_nxt.ack = wb_req;
    st_nxt.dat = '0;
    if (wb_req) begin
      if (wb_adr_i == ADR_STATUS) begin
        st_nxt.dat[EV_W-1:0] = st_r.sts;
        if (wb_we_i && wb_sel_i[0]) begin
          clr = wb_dat_i[EV_W-1:0];
        end
      end else if (wb_adr_i == ADR_MASK) begin
        st_nxt.dat[EV_W-1:0] = st_r.msk;
        if (wb_we_i && wb_sel_i[0]) begin
          st_nxt.msk = wb_dat_i[EV_W-1:0];
        end
      end else if (wb_adr_i == ADR_STATE) begin
        st_nxt.dat[ST_PARALLEL] = par_mode;
        st_nxt.dat[ST_READBACK] = st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT];
        st_nxt.dat[ST_STANDBY] = st_r.stby;
        st_nxt.dat[ST_BUFEN] = st_r.buf_en;
        st_nxt.dat[ST_PARCTRL] = st_r.par;
        st_nxt.dat[ST_PHASE_LSB+1:ST_PHASE_LSB] = st_r.phase;
      end else if (wb_adr_i == ADR_CFG) begin
        st_nxt.dat = st_r.cfg;
      end
    end
    // A new event wins over a clear in the same cycle.
    st_nxt.sts = (st_r.sts & ~clr) | ev;
    st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.cfg <= {CFG_N{CFG_DEFAULT}};
      st_r.msk <= MASK_RESET;
      st_r.phase <= PH_IDLE;
      st_r.drv_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign irq_o = st_r.irq;
  assign range_flag_or_readback_out_o = st_r.pin;
  assign buffers_en_o = st_r.buf_en;
  assign drivers_oe_n_o = st_r.drv_oe_n;
  assign standby_o = st_r.stby;
  assign parallel_ctrl_o = st_r.par;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pin stimulus passes three flip-flops before an output reflects it; the range input passes one.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_oe_on;
    output_drive_en_i [*4] |-> buffers_en_o && !drivers_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("buffers not enabled");

  property p_oe_off;
    !output_drive_en_i [*4] |-> !buffers_en_o && drivers_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers not released");

  property p_flag;
    !st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT] |=> range_flag_or_readback_out_o == $past(range_over_i);
  endproperty
  a_flag: assert property (p_flag) else $error("flag pin wrong");

  property p_readback;
    st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT] |=> range_flag_or_readback_out_o == $past(st_r.rd[7]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback pin wrong");

  property p_defaults;
    par_mode |=> st_r.cfg == {CFG_N{CFG_DEFAULT}};
  endproperty
  a_defaults: assert property (p_defaults) else $error("config not default");

  property p_parallel;
    par_mode ##1 par_mode |-> parallel_ctrl_o == $past(sel_n);
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel control wrong");

  property p_sclk_dead;
    par_mode |=> st_r.phase == PH_IDLE && st_r.bcnt == '0;
  endproperty
  a_sclk_dead: assert property (p_sclk_dead) else $error("shift in parallel mode");

  property p_shift_in;
    !par_mode && !sel_n && sclk_rise |=> st_r.shift[0] == $past(st_r.sy2[SY_SDIN]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit lost");

  property p_standby;
    par_mode ##1 par_mode |-> standby_o == $past(st_r.sy2[SY_SDIN]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not direct");

  property p_frame;
    !par_mode && sel_n |=> st_r.bcnt == '0 && st_r.phase == PH_IDLE;
  endproperty
  a_frame: assert property (p_frame) else $error("frame not ended");

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");

  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");

  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");

  property p_irq_on;
    (st_r.sts & st_r.msk) != '0 |-> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_irq_off;
    (st_r.sts & st_r.msk) == '0 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");

  property p_mode_ev;
    st_r.mode_d != par_mode |=> st_r.sts[EV_MODE];
  endproperty
  a_mode_ev: assert property (p_mode_ev) else $error("mode change not flagged");

  // A status bit may only fall through a write to the status register.
  property p_sticky;
    st_r.sts[EV_WRITE] && !(wb_req && wb_we_i && wb_adr_i == ADR_STATUS && wb_sel_i[0])
      |=> st_r.sts[EV_WRITE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_clear;
    wb_req && wb_we_i && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[EV_MODE] &&
      st_r.mode_d == par_mode |=> !st_r.sts[EV_MODE];
  endproperty
  a_clear: assert property (p_clear) else $error("status bit not cleared");

  property p_mask_wr;
    wb_req && wb_we_i && wb_adr_i == ADR_MASK && wb_sel_i[0]
      |=> st_r.msk == $past(wb_dat_i[EV_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_cfg_rd;
    wb_req && !wb_we_i && wb_adr_i == ADR_CFG |=> wb_dat_o == $past(st_r.cfg);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");

  property p_state_rd;
    wb_req && !wb_we_i && wb_adr_i == ADR_STATE |=> wb_dat_o[ST_PARALLEL] == $past(par_mode);
  endproperty
  a_state_rd: assert property (p_state_rd) else $error("mode read wrong");

  property p_serial_par;
    !par_mode |=> !parallel_ctrl_o;
  endproperty
  a_serial_par: assert property (p_serial_par) else $error("parallel output in serial mode");

  property p_serial_stby;
    !par_mode |=> standby_o == $past(st_r.cfg[CFG_PWR_IDX][CFG_STBY_BIT]);
  endproperty
  a_serial_stby: assert property (p_serial_stby) else $error("standby not from register");

  property p_swrst;
    ev[EV_SWRST] |=> st_r.cfg == {CFG_N{CFG_DEFAULT}};
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset incomplete");

  property p_rb_lock;
    !par_mode && st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT] && !ev[EV_SWRST]
      |=> $stable(st_r.cfg[CFG_N-1:1]);
  endproperty
  a_rb_lock: assert property (p_rb_lock) else $error("write in readback mode");

  property p_addr_load;
    !par_mode && !sel_n && sclk_rise && st_r.bcnt == ADDR_BITS - 5'h01 |=> st_r.phase == PH_DATA;
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address phase not ended");

  property p_frame_end;
    ev[EV_WRITE] |=> st_r.phase == PH_IDLE && st_r.bcnt == '0;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame not closed");

  property p_rd_zero;
    par_mode |=> st_r.rd == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("readback live in parallel mode");

  c_write: cover property (ev[EV_WRITE]);
  c_swrst: cover property (ev[EV_SWRST]);
  c_readback: cover property (st_r.cfg[CFG_CTRL_IDX][CFG_RB_BIT] && st_r.phase == PH_DATA);
  c_irq: cover property (irq_o);
  c_mode: cover property (ev[EV_MODE]);

endmodule
`default_nettype wire

// ### ctrl_pin_host.sv
// Behavioural host that drives the serial programming port of the control pin block.
`default_nettype none
module ctrl_pin_host (
  input wire logic clk_i,
  input wire logic flag_i,
  output logic sclk_o,
  output logic sdin_o,
  output logic sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: clock stands low, select high, data line low.
  initial begin
    sclk_o = 1'b0;
    sdin_o = 1'b0;
    sel_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame of sixteen bits, first bit most significant, 400 ns per shift clock.
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rb);
    logic [15:0] w;
    w = {a, d};
    rb = 8'h00;
    @(posedge clk_i);
    sel_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdin_o <= w[15-i];
      repeat (4) @(posedge clk_i);
      if (i > 7) rb = {rb[6:0], flag_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    sel_o <= 1'b1;
    // A released data line must not keep showing its last bit.
    sdin_o <= ~w[0];
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### tb_ctrl_pin_select.sv
// Self-checking bench of the control pin function select block.
`default_nettype none
module tb_ctrl_pin_select;
  import ctrl_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [WB_AW-1:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic reset_pin_i = 1'b1;
  logic output_drive_en_i = 1'b1;
  logic range_over_i = 1'b0;
  logic p_sdin = 1'b1;
  logic p_sel = 1'b1;
  logic wb_ack_o, irq_o, flag, bufen, oe_n, stby, pctl, sclk, h_sdin, h_sel;
  logic [31:0] wb_dat_o;
  logic [7:0] rb;
  logic [1:0] h;
  logic [16:0] lfsr = 17'd67394;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  initial forever #25 clk_i = ~clk_i;
  ctrl_pin_host host (.clk_i(clk_i), .flag_i(flag), .sclk_o(sclk), .sdin_o(h_sdin), .sel_o(h_sel));
  ctrl_pin_select dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o), .reset_pin_i(reset_pin_i),
    .sclk_i(sclk), .serial_in_line_i(reset_pin_i ? p_sdin : h_sdin),
    .serial_select_i(reset_pin_i ? p_sel : h_sel), .output_drive_en_i(output_drive_en_i),
    .range_over_i(range_over_i), .range_flag_or_readback_out_o(flag), .buffers_en_o(bufen),
    .drivers_oe_n_o(oe_n), .standby_o(stby), .parallel_ctrl_o(pctl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read results are compared by the watcher below, oldest note first.
  always @(negedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) check("rdata", wb_dat_o,
      exp_q.pop_front());
  end
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Ack is looked at mid-cycle; the request is released at the edge that samples it high.
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    @(posedge clk_i);
    if (n >= 20) check("ack", 0, 1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    wb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic settle();
    repeat (5) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500_000;
    check("watchdog", 0, 1);
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    rd(ADR_STATE, 32'h0000_001d);
    check("pctl", pctl, 1);
    check("stby", stby, 1);
    check("oe_n", oe_n, 0);
    host.frame(8'h01, 8'h01, rb);
    rd(ADR_CFG, 32'h0000_0000);
    // The flag pin lags the range input by one clock; it is read mid-cycle.
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      h = {h[0], lfsr[0]};
      range_over_i <= lfsr[0];
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      @(negedge clk_i);
      if (i > 0) check("flag", flag, h[1]);
    end
    @(posedge clk_i);
    $display("test parallel done");
    output_drive_en_i <= 1'b0;
    settle();
    check("bufen", bufen, 0);
    check("oe_n", oe_n, 1);
    output_drive_en_i <= 1'b1;
    reset_pin_i <= 1'b0;
    settle();
    check("pctl", pctl, 0);
    check("bufen", bufen, 1);
    host.frame(8'h01, 8'h01, rb);
    check("stby", stby, 1);
    rd(ADR_CFG, 32'h0000_0100);
    rd(ADR_STATUS, 32'h0000_0005);
    wb(ADR_MASK, 1'b1, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    check("irq", irq_o, 1);
    wb(ADR_STATUS, 1'b1, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    check("irq", irq_o, 0);
    rd(4'h2, 32'h0000_0000);
    $display("test serial done");
    // Readback mode: register one comes back on the shared pin, writes to it drop.
    host.frame(8'h00, 8'h01, rb);
    host.frame(8'h01, 8'h55, rb);
    check("readback", rb, 8'h01);
    rd(ADR_CFG, 32'h0000_0101);
    host.frame(8'h00, 8'h02, rb);
    rd(ADR_CFG, 32'h0000_0000);
    check("stby", stby, 0);
    $display("test readback done");
    p_sel <= 1'b0;
    reset_pin_i <= 1'b1;
    settle();
    check("pctl", pctl, 0);
    $display("test return done");
    final_report();
  end
endmodule
`default_nettype wire
